// *** hdl/mbt_defines.svh ***
// Constants for the branch, trap, OR and store execution slice.
`ifndef MBT_DEFINES_SVH
`define MBT_DEFINES_SVH

// ============================================================
// Field positions
`define MBT_PC_HI_MSB 9
`define MBT_PC_HI_LSB 8
`define MBT_PTR_HI_MSB 1
`define MBT_PTR_HI_LSB 0

// ============================================================
// Reset values and fixed addresses
`define MBT_TRAP_VECTOR 10'h001
`define MBT_PC_RESET 10'h000
`define MBT_DATA_RESET 8'h00
`define MBT_ZERO_DATA 8'h00
`define MBT_ALL_ONES 8'hff
`define MBT_PC_STEP 10'h001
`define MBT_DATA_STEP 8'h01

// ============================================================
// Timing counts in instruction cycles
`define MBT_BRANCH_CYCLES 2
`define MBT_TRAP_CYCLES 3
`define MBT_SKIP_CYCLES 2
`define MBT_SIMPLE_CYCLES 1

`endif

// *** hdl/mbt_pkg.sv ***
// Types shared by the execution slice.
package mbt_pkg;

   // ============================================================
   // Operation select from the decoder
   typedef enum logic [2:0] {
      MBT_OP_NONE = 3'h0,
      MBT_OP_INDIRECT_BRANCH = 3'h1,
      MBT_OP_INCREMENT_SKIP_ZERO = 3'h2,
      MBT_OP_SOFT_TRAP = 3'h3,
      MBT_OP_OR_IMMEDIATE = 3'h4,
      MBT_OP_OR_WITH_REGISTER = 3'h5,
      MBT_OP_SPECIAL_PAGE_STORE = 3'h6
   } mbt_op_e;

   // ============================================================
   // Sequencer states, one-hot
   typedef enum logic [4:0] {
      MBT_ST_IDLE = 5'h01,
      MBT_ST_BRANCH2 = 5'h02,
      MBT_ST_TRAP2 = 5'h04,
      MBT_ST_TRAP3 = 5'h08,
      MBT_ST_SKIP2 = 5'h10
   } mbt_state_e;

endpackage : mbt_pkg

// *** hdl/mbt_exec.sv ***
// Execution slice: indirect branch, increment-skip, trap, OR operations, special store.
//
// Function
// - Branch loads PC from pointer bits and working register.
// - Branch unconditional, no flags, two cycles.
// - Increment register, destination bit picks target.
// - Zero sum flushes next instruction, two cycles.
// - Trap pushes return address, vectors to 0x001.
// - OR literal into working register, zero flag.
// - OR register, destination bit picks target.
// - Store working register into special page register.
`include "mbt_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module mbt_exec
   import mbt_pkg::*;
#(
   parameter int REG_ADDR_W = 6,
   parameter int SFR_ADDR_W = 4
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst,
   // Issue from the decoder
   input wire logic i_start,
   input wire mbt_op_e i_op,
   input wire logic i_dest,
   input wire logic [REG_ADDR_W-1:0] i_reg_addr,
   input wire logic [SFR_ADDR_W-1:0] i_sfr_addr,
   input wire logic [7:0] i_literal,
   // Core state
   input wire logic [7:0] i_acc,
   input wire logic [7:0] i_reg_rdata,
   input wire logic [7:0] i_table_high_pointer,
   input wire logic [9:0] i_pc,
   // Sequencing
   output logic o_busy,
   output logic o_done,
   output logic o_flush,
   // Program counter and stack
   output logic o_pc_load,
   output logic [9:0] o_pc_value,
   output logic o_push,
   output logic [9:0] o_push_addr,
   // Working register and flag
   output logic o_acc_we,
   output logic [7:0] o_acc_wdata,
   output logic o_zero_we,
   output logic o_zero,
   // Register file
   output logic o_reg_we,
   output logic [REG_ADDR_W-1:0] o_reg_waddr,
   output logic [7:0] o_reg_wdata,
   // Special page
   output logic o_sfr_we,
   output logic [SFR_ADDR_W-1:0] o_sfr_addr,
   output logic [7:0] o_sfr_wdata
);

   // ============================================================
   // Elaboration checks
   if (REG_ADDR_W < 1 || REG_ADDR_W > 8 || SFR_ADDR_W < 1 || SFR_ADDR_W > 8) begin : g_bad_width
      $error("Address width parameter out of range.");
   end

   // ============================================================
   // State
   mbt_state_e state_reg, state_next;
   logic busy_reg, busy_next, done_reg, done_next, flush_reg, flush_next;
   logic pc_load_reg, pc_load_next, push_reg, push_next;
   logic [9:0] pc_value_reg, pc_value_next, push_addr_reg, push_addr_next;
   logic acc_we_reg, acc_we_next, zero_we_reg, zero_we_next, zero_reg, zero_next;
   logic [7:0] acc_wdata_reg, acc_wdata_next, reg_wdata_reg, reg_wdata_next;
   logic reg_we_reg, reg_we_next, sfr_we_reg, sfr_we_next, take;
   logic [REG_ADDR_W-1:0] reg_waddr_reg, reg_waddr_next;
   logic [SFR_ADDR_W-1:0] sfr_addr_reg, sfr_addr_next;
   logic [7:0] sfr_wdata_reg, sfr_wdata_next;
   logic [7:0] inc_sum, or_reg_res, or_imm_res;

   // A request is only taken while idle; a request held up during o_busy is ignored.
   assign take = i_start && (state_reg == MBT_ST_IDLE);
   assign inc_sum = i_reg_rdata + `MBT_DATA_STEP;
   assign or_reg_res = i_acc | i_reg_rdata;
   assign or_imm_res = i_acc | i_literal;

   // ============================================================
   // Next-state and output computation
   always_comb begin
      state_next = state_reg;
      done_next = 1'b0;
      flush_next = 1'b0;
      pc_load_next = 1'b0;
      pc_value_next = pc_value_reg;
      push_next = 1'b0;
      push_addr_next = push_addr_reg;
      acc_we_next = 1'b0;
      acc_wdata_next = acc_wdata_reg;
      zero_we_next = 1'b0;
      zero_next = zero_reg;
      reg_we_next = 1'b0;
      reg_waddr_next = reg_waddr_reg;
      reg_wdata_next = reg_wdata_reg;
      sfr_we_next = 1'b0;
      sfr_addr_next = sfr_addr_reg;
      sfr_wdata_next = sfr_wdata_reg;
      case (state_reg)
         MBT_ST_IDLE: begin
            if (take) begin
               case (i_op)
                  MBT_OP_INDIRECT_BRANCH: begin
                     pc_load_next = 1'b1;
                     pc_value_next = {i_table_high_pointer[`MBT_PTR_HI_MSB:`MBT_PTR_HI_LSB], i_acc};
                     state_next = MBT_ST_BRANCH2;
                  end
                  MBT_OP_INCREMENT_SKIP_ZERO: begin
                     acc_we_next = !i_dest;
                     acc_wdata_next = inc_sum;
                     reg_we_next = i_dest;
                     reg_waddr_next = i_reg_addr;
                     reg_wdata_next = inc_sum;
                     done_next = (inc_sum != `MBT_ZERO_DATA);
                     if (inc_sum == `MBT_ZERO_DATA) begin
                        flush_next = 1'b1;
                        state_next = MBT_ST_SKIP2;
                     end
                  end
                  MBT_OP_SOFT_TRAP: begin
                     push_next = 1'b1;
                     push_addr_next = i_pc + `MBT_PC_STEP;
                     state_next = MBT_ST_TRAP2;
                  end
                  MBT_OP_OR_IMMEDIATE: begin
                     acc_we_next = 1'b1;
                     acc_wdata_next = or_imm_res;
                     zero_we_next = 1'b1;
                     zero_next = (or_imm_res == `MBT_ZERO_DATA);
                     done_next = 1'b1;
                  end
                  MBT_OP_OR_WITH_REGISTER: begin
                     acc_we_next = !i_dest;
                     acc_wdata_next = or_reg_res;
                     reg_we_next = i_dest;
                     reg_waddr_next = i_reg_addr;
                     reg_wdata_next = or_reg_res;
                     zero_we_next = 1'b1;
                     zero_next = (or_reg_res == `MBT_ZERO_DATA);
                     done_next = 1'b1;
                  end
                  MBT_OP_SPECIAL_PAGE_STORE: begin
                     sfr_we_next = 1'b1;
                     sfr_addr_next = i_sfr_addr;
                     sfr_wdata_next = i_acc;
                     done_next = 1'b1;
                  end
                  default: done_next = 1'b0;
               endcase
            end
         end
         MBT_ST_BRANCH2: begin
            done_next = 1'b1;
            state_next = MBT_ST_IDLE;
         end
         MBT_ST_TRAP2: begin
            // The vector load follows the push so the stack sees the old return address first.
            pc_load_next = 1'b1;
            pc_value_next = `MBT_TRAP_VECTOR;
            state_next = MBT_ST_TRAP3;
         end
         MBT_ST_TRAP3: begin
            done_next = 1'b1;
            state_next = MBT_ST_IDLE;
         end
         MBT_ST_SKIP2: begin
            done_next = 1'b1;
            state_next = MBT_ST_IDLE;
         end
         default: state_next = MBT_ST_IDLE;
      endcase
      busy_next = (state_next != MBT_ST_IDLE);
   end

   // ============================================================
   // Registers
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         state_reg <= MBT_ST_IDLE;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
         flush_reg <= 1'b0;
         pc_load_reg <= 1'b0;
         pc_value_reg <= `MBT_PC_RESET;
         push_reg <= 1'b0;
         push_addr_reg <= `MBT_PC_RESET;
         acc_we_reg <= 1'b0;
         acc_wdata_reg <= `MBT_DATA_RESET;
         zero_we_reg <= 1'b0;
         zero_reg <= 1'b0;
         reg_we_reg <= 1'b0;
         reg_waddr_reg <= '0;
         reg_wdata_reg <= `MBT_DATA_RESET;
         sfr_we_reg <= 1'b0;
         sfr_addr_reg <= '0;
         sfr_wdata_reg <= `MBT_DATA_RESET;
      end else begin
         state_reg <= state_next;
         busy_reg <= busy_next;
         done_reg <= done_next;
         flush_reg <= flush_next;
         pc_load_reg <= pc_load_next;
         pc_value_reg <= pc_value_next;
         push_reg <= push_next;
         push_addr_reg <= push_addr_next;
         acc_we_reg <= acc_we_next;
         acc_wdata_reg <= acc_wdata_next;
         zero_we_reg <= zero_we_next;
         zero_reg <= zero_next;
         reg_we_reg <= reg_we_next;
         reg_waddr_reg <= reg_waddr_next;
         reg_wdata_reg <= reg_wdata_next;
         sfr_we_reg <= sfr_we_next;
         sfr_addr_reg <= sfr_addr_next;
         sfr_wdata_reg <= sfr_wdata_next;
      end
   end

   assign o_busy = busy_reg;
   assign o_done = done_reg;
   assign o_flush = flush_reg;
   assign o_pc_load = pc_load_reg;
   assign o_pc_value = pc_value_reg;
   assign o_push = push_reg;
   assign o_push_addr = push_addr_reg;
   assign o_acc_we = acc_we_reg;
   assign o_acc_wdata = acc_wdata_reg;
   assign o_zero_we = zero_we_reg;
   assign o_zero = zero_reg;
   assign o_reg_we = reg_we_reg;
   assign o_reg_waddr = reg_waddr_reg;
   assign o_reg_wdata = reg_wdata_reg;
   assign o_sfr_we = sfr_we_reg;
   assign o_sfr_addr = sfr_addr_reg;
   assign o_sfr_wdata = sfr_wdata_reg;

   // ============================================================
   // Assertions
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_rst);

   sequence s_trap_push;
      o_push && !o_pc_load && o_busy && !o_zero_we;
   endsequence
   sequence s_trap_vector;
      o_pc_load && (o_pc_value == `MBT_TRAP_VECTOR) && !o_push && o_busy && !o_zero_we;
   endsequence
   sequence s_finish;
      o_done && !o_busy;
   endsequence

   a_branch_pc_value: assert property (take && i_op == MBT_OP_INDIRECT_BRANCH |=> o_pc_load &&
      o_pc_value == {$past(i_table_high_pointer[1:0]), $past(i_acc)})
      else $error("indirect branch target wrong");
   a_branch_two_cyc: assert property (take && i_op == MBT_OP_INDIRECT_BRANCH |=>
      (o_busy && !o_done && !o_zero_we) ##1 (s_finish and !o_zero_we and !o_pc_load))
      else $error("indirect branch not two cycles or touched flags");
   a_incr_dest: assert property (take && i_op == MBT_OP_INCREMENT_SKIP_ZERO |=>
      (o_reg_we == $past(i_dest)) && (o_acc_we != $past(i_dest)) && !o_zero_we &&
      (o_reg_wdata == 8'($past(i_reg_rdata) + 8'h01)) && (o_reg_waddr == $past(i_reg_addr)))
      else $error("increment result or target wrong");
   a_skip_zero: assert property (take && i_op == MBT_OP_INCREMENT_SKIP_ZERO && i_reg_rdata == 8'hff |=>
      (o_flush && o_busy) ##1 (s_finish and !o_flush))
      else $error("zero increment did not skip");
   a_no_skip: assert property (take && i_op == MBT_OP_INCREMENT_SKIP_ZERO && i_reg_rdata != 8'hff |=>
      (!o_flush and s_finish))
      else $error("nonzero increment skipped");
   a_trap_seq: assert property (take && i_op == MBT_OP_SOFT_TRAP |=>
      s_trap_push ##1 s_trap_vector ##1 s_finish)
      else $error("trap sequence wrong");
   a_trap_ret: assert property (take && i_op == MBT_OP_SOFT_TRAP |=> o_push_addr == 10'($past(i_pc) + 10'h001))
      else $error("trap return address wrong");
   a_or_imm: assert property (take && i_op == MBT_OP_OR_IMMEDIATE |=> s_finish and
      (o_acc_we && o_zero_we && !o_reg_we && o_acc_wdata == ($past(i_acc) | $past(i_literal))))
      else $error("or immediate wrong");
   a_or_reg: assert property (take && i_op == MBT_OP_OR_WITH_REGISTER |=> s_finish and
      (o_zero_we && (o_reg_we == $past(i_dest)) && (o_acc_we != $past(i_dest)) &&
      (o_reg_wdata == ($past(i_acc) | $past(i_reg_rdata)))))
      else $error("or with register wrong");
   a_sfr_store: assert property (take && i_op == MBT_OP_SPECIAL_PAGE_STORE |=> s_finish and
      (o_sfr_we && !o_zero_we && o_sfr_wdata == $past(i_acc) && o_sfr_addr == $past(i_sfr_addr)))
      else $error("special store wrong");
   a_zero_flag: assert property (o_zero_we |->
      o_zero == (((o_acc_we ? o_acc_wdata : o_reg_wdata)) == 8'h00))
      else $error("zero flag does not match result");

endmodule : mbt_exec

`default_nettype wire

// *** dv/mbt_exec_test.sv ***
// Self-checking testbench for the execution slice.
`timescale 1ns/10ps
`default_nettype none

module mbt_exec_test;
   import mbt_pkg::*;
   // ============================================================
   // Signals
   logic i_mclk, i_rst, i_start, i_dest;
   mbt_op_e i_op;
   logic [5:0] i_reg_addr;
   logic [3:0] i_sfr_addr;
   logic [7:0] i_literal, i_acc, i_reg_rdata, i_table_high_pointer;
   logic [9:0] i_pc;
   logic o_busy, o_done, o_flush, o_pc_load, o_push, o_acc_we, o_zero_we, o_zero, o_reg_we, o_sfr_we;
   logic [9:0] o_pc_value, o_push_addr;
   logic [7:0] o_acc_wdata, o_reg_wdata, o_sfr_wdata;
   logic [5:0] o_reg_waddr;
   logic [3:0] o_sfr_addr;
   logic [31:0] r1, r2;
   int errors, comparisons, seed;
   wire logic [9:0] strobes;
   assign strobes = {1'b0, o_busy, o_done, o_flush, o_pc_load, o_push, o_acc_we, o_zero_we, o_reg_we, o_sfr_we};

   mbt_exec DUT (.i_mclk(i_mclk), .i_rst(i_rst), .i_start(i_start), .i_op(i_op), .i_dest(i_dest),
      .i_reg_addr(i_reg_addr), .i_sfr_addr(i_sfr_addr), .i_literal(i_literal), .i_acc(i_acc),
      .i_reg_rdata(i_reg_rdata), .i_table_high_pointer(i_table_high_pointer), .i_pc(i_pc),
      .o_busy(o_busy), .o_done(o_done), .o_flush(o_flush), .o_pc_load(o_pc_load), .o_pc_value(o_pc_value),
      .o_push(o_push), .o_push_addr(o_push_addr), .o_acc_we(o_acc_we), .o_acc_wdata(o_acc_wdata),
      .o_zero_we(o_zero_we), .o_zero(o_zero), .o_reg_we(o_reg_we), .o_reg_waddr(o_reg_waddr),
      .o_reg_wdata(o_reg_wdata), .o_sfr_we(o_sfr_we), .o_sfr_addr(o_sfr_addr), .o_sfr_wdata(o_sfr_wdata));

   initial begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end

   // ============================================================
   // Helpers
   task automatic close_out();
      $display("comparisons %0d, errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : close_out

   task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk

   // Strobe bits: busy, done, flush, pc_load, push, acc_we, zero_we, reg_we, sfr_we.
   function automatic logic [9:0] exp_strobes(input mbt_op_e op, input logic d, input logic z, input int c);
      logic [9:0] we;
      we = d ? 10'h002 : 10'h008;
      case (op)
         MBT_OP_INDIRECT_BRANCH: return (c == 1) ? 10'h120 : 10'h080;
         MBT_OP_INCREMENT_SKIP_ZERO: return z ? ((c == 1) ? (10'h140 | we) : 10'h080) : (10'h080 | we);
         MBT_OP_SOFT_TRAP: return (c == 1) ? 10'h110 : (c == 2) ? 10'h120 : 10'h080;
         MBT_OP_OR_IMMEDIATE: return 10'h08c;
         MBT_OP_OR_WITH_REGISTER: return 10'h084 | we;
         MBT_OP_SPECIAL_PAGE_STORE: return 10'h081;
         default: return 10'h000;
      endcase
   endfunction : exp_strobes

   // Issues one instruction and follows it cycle by cycle; while busy a second request is held up,
   // which must be ignored. Leaves the request asserted so that the next call runs back to back.
   task automatic run_op(input mbt_op_e op, input logic d, input logic [7:0] acc, input logic [7:0] rd,
                         input logic [7:0] lit, input logic [5:0] ra, input logic [3:0] sa,
                         input logic [7:0] tb, input logic [9:0] pc);
      logic [7:0] res;
      logic z;
      logic [9:0] e;
      int n;
      res = (op == MBT_OP_INCREMENT_SKIP_ZERO) ? rd + 8'h01 : acc | ((op == MBT_OP_OR_IMMEDIATE) ? lit : rd);
      z = (op == MBT_OP_INCREMENT_SKIP_ZERO) && (res == 8'h00);
      n = (op == MBT_OP_INDIRECT_BRANCH || z) ? 2 : (op == MBT_OP_SOFT_TRAP) ? 3 : 1;
      i_start = 1'b1;
      i_op = op;
      i_dest = d;
      i_acc = acc;
      i_reg_rdata = rd;
      i_literal = lit;
      i_reg_addr = ra;
      i_sfr_addr = sa;
      i_table_high_pointer = tb;
      i_pc = pc;
      for (int c = 1; c <= n; c++) begin
         @(negedge i_mclk);
         e = exp_strobes(op, d, z, c);
         chk("strobes", e, strobes);
         if (e[5]) chk("pc_value", (op == MBT_OP_SOFT_TRAP) ? 10'h001 : {tb[1:0], acc}, o_pc_value);
         if (e[4]) chk("push_addr", pc + 10'h001, o_push_addr);
         if (e[3]) chk("acc_wdata", {2'b00, res}, {2'b00, o_acc_wdata});
         if (e[1]) chk("reg_wdata", {2'b00, res}, {2'b00, o_reg_wdata});
         if (e[1]) chk("reg_waddr", {4'h0, ra}, {4'h0, o_reg_waddr});
         if (e[2]) chk("zero", {9'h000, res == 8'h00}, {9'h000, o_zero});
         if (e[0]) chk("sfr_wdata", {2'b00, acc}, {2'b00, o_sfr_wdata});
         if (e[0]) chk("sfr_addr", {6'h00, sa}, {6'h00, o_sfr_addr});
         if (c < n) begin
            i_op = MBT_OP_OR_IMMEDIATE;
         end
      end
   endtask : run_op

   // ============================================================
   // Main sequence
   initial begin
      seed = 19361;
      errors = 0;
      comparisons = 0;
      i_rst = 1'b1;
      i_start = 1'b0;
      i_op = MBT_OP_NONE;
      i_dest = 1'b0;
      i_reg_addr = 6'h00;
      i_sfr_addr = 4'h0;
      i_literal = 8'h00;
      i_acc = 8'h00;
      i_reg_rdata = 8'h00;
      i_table_high_pointer = 8'h00;
      i_pc = 10'h000;
      repeat (6) @(negedge i_mclk);
      chk("reset strobes", 10'h000, strobes);
      i_rst = 1'b0;
      @(negedge i_mclk);
      run_op(MBT_OP_INDIRECT_BRANCH, 1'b0, 8'h34, 8'h00, 8'h00, 6'h00, 4'h0, 8'h02, 10'h0a0);
      run_op(MBT_OP_INDIRECT_BRANCH, 1'b1, 8'hff, 8'h00, 8'h00, 6'h3f, 4'hf, 8'hfd, 10'h3ff);
      run_op(MBT_OP_INCREMENT_SKIP_ZERO, 1'b1, 8'h12, 8'hff, 8'h00, 6'h3f, 4'h0, 8'h00, 10'h010);
      run_op(MBT_OP_INCREMENT_SKIP_ZERO, 1'b0, 8'h12, 8'hff, 8'h00, 6'h00, 4'h0, 8'h00, 10'h011);
      run_op(MBT_OP_INCREMENT_SKIP_ZERO, 1'b0, 8'h00, 8'hfe, 8'h00, 6'h15, 4'h0, 8'h00, 10'h012);
      run_op(MBT_OP_INCREMENT_SKIP_ZERO, 1'b1, 8'h00, 8'h7f, 8'h00, 6'h2a, 4'h0, 8'h00, 10'h013);
      run_op(MBT_OP_SOFT_TRAP, 1'b0, 8'h55, 8'h00, 8'h00, 6'h00, 4'h0, 8'h03, 10'h3ff);
      run_op(MBT_OP_SOFT_TRAP, 1'b1, 8'h00, 8'h00, 8'h00, 6'h00, 4'h0, 8'h00, 10'h0a0);
      run_op(MBT_OP_OR_IMMEDIATE, 1'b1, 8'haa, 8'h00, 8'h50, 6'h00, 4'h0, 8'h00, 10'h020);
      run_op(MBT_OP_OR_IMMEDIATE, 1'b0, 8'h00, 8'h33, 8'h00, 6'h00, 4'h0, 8'h00, 10'h021);
      run_op(MBT_OP_OR_WITH_REGISTER, 1'b1, 8'haa, 8'h50, 8'h00, 6'h3f, 4'h0, 8'h00, 10'h022);
      run_op(MBT_OP_OR_WITH_REGISTER, 1'b0, 8'h00, 8'h00, 8'hff, 6'h01, 4'h0, 8'h00, 10'h023);
      run_op(MBT_OP_SPECIAL_PAGE_STORE, 1'b1, 8'haa, 8'h00, 8'h00, 6'h00, 4'hf, 8'h00, 10'h024);
      run_op(MBT_OP_NONE, 1'b1, 8'hff, 8'hff, 8'hff, 6'h3f, 4'hf, 8'hff, 10'h025);
      $display("corner test done, errors %0d", errors);
      for (int k = 0; k < 200; k++) begin
         r1 = $random(seed);
         r2 = $random(seed);
         run_op(mbt_op_e'(r1[2:0]), r1[3], r1[21:14], r1[29:22], r2[7:0], r1[9:4], r1[13:10], r2[15:8],
                r2[25:16]);
      end
      $display("random test done, errors %0d", errors);
      i_start = 1'b0;
      @(negedge i_mclk);
      close_out();
   end

   // A hang is cut short here and counted as a mismatch.
   initial begin
      repeat (20000) @(posedge i_mclk);
      errors++;
      $display("unexpected run length: expected end within 20000 cycles, seen timeout");
      close_out();
   end

endmodule : mbt_exec_test

`default_nettype wire
